// file: core/adcseq_pkg.sv
// Purpose: constants and state types for the converter sequencer
// Assumes: one system clock; conversion clock select uses 3-bit codes
// Notes on behaviour
// RULE_01: result pair left or right justified
// RULE_02: done flag set after every conversion
// RULE_03: done flag sticks until software clears
// RULE_04: irq only when flag and enable set
// RULE_05: enabled irq wakes sleeping device
// RULE_06: go starts conversion only while on
// RULE_07: software sets go after turning on
// RULE_08: finish clears go, sets flag, loads result
// RULE_09: software abort loads partial, fills lower bits
// RULE_10: reset clears everything, aborts conversion
// RULE_11: sleep needs rc clock; rc adds instruction delay
// RULE_12: sleep, irq off: power down after finish
// RULE_13: sleep without rc clock aborts, powers down
// RULE_14: compare trigger sets go, clears timer one
// RULE_15: trigger user ensures acquisition timing
// RULE_16: software waits acquisition, polls or interrupts
// RULE_17: 11.5 bit periods, msb first
// RULE_18: clock is fosc/2..64 or rc oscillator
// RULE_19: channel select; off disconnects multiplexer
// RULE_20: go while off does nothing
package adcseq_pkg;
  localparam int unsigned RES_W        = 10;
  localparam logic [3:0]  BIT_CNT      = 4'hA;
  localparam logic [4:0]  HALF_TADS    = 5'h17; // 11.5 bit periods
  localparam logic [4:0]  FIRST_BIT_PH = 5'h04; // end of second period
  localparam logic [2:0]  INSTR_CLKS   = 3'h4;  // one instruction cycle
  localparam logic [1:0]  SEL_FRC      = 2'h3;  // low select bits for rc
  localparam logic [9:0]  TRIAL_MSB    = 10'h200;
  localparam logic [5:0]  PAD_ZERO     = 6'h00;
  localparam logic [5:0]  DIV_ONE      = 6'h01;

  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_CONV} adcseq_st_t;

  typedef struct packed {
    adcseq_st_t  st;
    logic        go;
    logic        flag;
    logic        pd;
    logic        hold_open;
    logic        t1clr;
    logic [2:0]  dly;
    logic [4:0]  ph;
    logic [3:0]  left;
    logic [9:0]  sar;
    logic [9:0]  trial;
    logic [7:0]  hi;
    logic [7:0]  lo;
    logic [4:0]  chan;
    logic        c1;
    logic        c2;
  } adcseq_state_t;

  typedef struct packed {
    logic        f1;
    logic        f2;
    logic        f3;
    logic [4:0]  cnt;
    logic        tick;
  } adcseq_tad_st_t;
endpackage : adcseq_pkg

// file: core/adcseq_tad_if.sv
// Purpose: link between sequencer and bit-period generator
// Assumes: all signals on clk_sys
// Notes: half_tick marks half a bit period
`timescale 1ns/1ps
`default_nettype none
interface adcseq_tad_if;
  logic       run;
  logic [2:0] sel;
  logic       half_tick;
  modport gen (input run, input sel, output half_tick);
  modport seq (output run, output sel, input half_tick);
endinterface : adcseq_tad_if
`default_nettype wire

// file: core/adcseq_tad.sv
// Purpose: half bit-period ticks from divided clock or rc oscillator
// Assumes: rc oscillator slower than a quarter of clk_sys
// Notes: both rc edges count, so one rc period is one bit period
`timescale 1ns/1ps
`default_nettype none
module adcseq_tad (
  input wire logic     clk_sys,
  input wire logic     arst_n,
  input wire logic     frc_osc,
  adcseq_tad_if.gen    tad
);
  import adcseq_pkg::*;

  adcseq_tad_st_t q;
  adcseq_tad_st_t n;
  logic [2:0]     expo;
  logic [4:0]     lim;

  ////////////////////////////////////////////////////////////////////////////
  // select code maps to divide exponent: 000,100,001,101,010,110
  assign expo = {tad.sel[1:0], tad.sel[2]};
  assign lim  = 5'((DIV_ONE << expo) - DIV_ONE);

  // divider restarts with each conversion so the first period is whole
  always_comb begin
    n      = q;
    n.f1   = frc_osc;
    n.f2   = q.f1;
    n.f3   = q.f2;
    n.tick = 1'b0;
    if (!tad.run) begin
      n.cnt = '0;
    end else if (tad.sel[1:0] == SEL_FRC) begin
      n.tick = q.f2 ^ q.f3; // RULE_18
    end else if (q.cnt == lim) begin
      n.cnt  = '0;
      n.tick = 1'b1; // RULE_18
    end else begin
      n.cnt = q.cnt + 5'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign tad.half_tick = q.tick;
endmodule : adcseq_tad
`default_nettype wire

// file: core/adcseq_top.sv
// Purpose: successive-approximation converter control and sequencing
// Assumes: software strobes are one-cycle pulses on clk_sys
// Notes: comparator and rc oscillator are asynchronous and synchronised
`timescale 1ns/1ps
`default_nettype none
module adcseq_top (
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  input  wire logic       frc_osc,
  input  wire logic       comparator_high,
  input  wire logic       converter_on,
  input  wire logic       go_write_set,
  input  wire logic       go_write_clear,
  input  wire logic [2:0] conversion_clock_select,
  input  wire logic       result_justify_select,
  input  wire logic [4:0] input_channel_select,
  input  wire logic       conversion_irq_enable,
  input  wire logic       flag_clear,
  input  wire logic       device_sleep,
  input  wire logic       special_event_trigger,
  output logic            go_busy,
  output logic            conversion_done_flag,
  output logic            converter_irq,
  output logic            wake_request,
  output logic [7:0]      result_high_byte,
  output logic [7:0]      result_low_byte,
  output logic [9:0]      sar_trial_code,
  output logic            hold_connected,
  output logic [4:0]      mux_channel,
  output logic            mux_connected,
  output logic            converter_powered,
  output logic            timer_one_clear
);
  import adcseq_pkg::*;

  adcseq_state_t q;
  adcseq_state_t n;
  logic          frc_sel;
  logic          sleep_kill;
  logic          start_req;
  logic          done_evt;

  adcseq_tad_if  tad_if ();

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // not-yet-converted bits copy the last decided bit
  function automatic logic [9:0] adcseq_fill(input logic [9:0] v,
                                             input logic [3:0] left);
    logic [9:0] r;
    logic       last;
    r    = v;
    last = (left < BIT_CNT) ? v[left] : 1'b0;
    for (int i = 0; i < RES_W; i++) begin
      if (4'(i) < left) begin
        r[i] = last; // RULE_09
      end
    end
    return r;
  endfunction : adcseq_fill

  // format is taken at load time, later select changes do not reformat
  function automatic logic [15:0] adcseq_pack(input logic [9:0] v,
                                              input logic       right);
    return right ? {PAD_ZERO, v} : {v, PAD_ZERO}; // RULE_01
  endfunction : adcseq_pack

  ////////////////////////////////////////////////////////////////////////////
  // bit period generator
  assign tad_if.run = (q.st == ST_CONV);
  assign tad_if.sel = conversion_clock_select;

  adcseq_tad u_tad (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .frc_osc (frc_osc),
    .tad     (tad_if.gen)
  );

  ////////////////////////////////////////////////////////////////////////////
  // start qualification
  assign frc_sel    = (conversion_clock_select[1:0] == SEL_FRC);
  assign sleep_kill = device_sleep & ~frc_sel; // RULE_11 RULE_13
  // a go while off or in non-rc sleep is dropped outright
  assign start_req  = (go_write_set | special_event_trigger) & converter_on
                    & ~sleep_kill; // RULE_06 RULE_14 RULE_20

  // next state
  always_comb begin
    n        = q;
    done_evt = 1'b0;
    n.c1     = comparator_high;
    n.c2     = q.c1;
    n.t1clr  = special_event_trigger; // RULE_14
    n.chan   = input_channel_select; // RULE_19
    if (!device_sleep || !converter_on) begin
      n.pd = 1'b0;
    end
    unique case (q.st)
      ST_IDLE: begin
        if (start_req) begin
          n.go   = 1'b1; // RULE_06 RULE_14
          n.st   = frc_sel ? ST_DELAY : ST_CONV; // RULE_11
          n.dly  = '0;
          n.ph   = '0;
          n.sar  = '0;
          n.left = BIT_CNT;
        end
      end
      ST_DELAY, ST_CONV: begin
        if (!converter_on) begin
          n.go = 1'b0;
          n.st = ST_IDLE;
        end else if (sleep_kill) begin
          n.go = 1'b0; // RULE_13
          n.st = ST_IDLE;
          n.pd = 1'b1; // RULE_13
        end else if (go_write_clear) begin
          n.go = 1'b0;
          n.st = ST_IDLE;
          {n.hi, n.lo} = adcseq_pack(adcseq_fill(q.sar, q.left),
                                     result_justify_select); // RULE_09
        end else if (q.st == ST_DELAY) begin
          if (q.dly == INSTR_CLKS - 3'h1) begin
            n.st = ST_CONV; // RULE_11
          end else begin
            n.dly = q.dly + 3'h1;
          end
        end else if (tad_if.half_tick) begin
          n.ph = q.ph + 5'h01;
          // one bit decided at the end of each period from the second on, msb first
          if (n.ph >= FIRST_BIT_PH && !n.ph[0] && q.left != 4'h0) begin
            n.sar[q.left - 4'h1] = q.c2; // RULE_17
            n.left = q.left - 4'h1; // RULE_17
          end
          if (n.ph == HALF_TADS) begin
            done_evt = 1'b1; // RULE_02 RULE_17
            n.go     = 1'b0; // RULE_08
            n.st     = ST_IDLE;
            {n.hi, n.lo} = adcseq_pack(q.sar, result_justify_select); // RULE_08
            n.pd     = device_sleep & ~conversion_irq_enable; // RULE_12
          end
        end
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase
    // set beats a simultaneous software clear
    n.flag      = (q.flag & ~flag_clear) | done_evt; // RULE_02 RULE_03
    n.hold_open = (n.st == ST_CONV);
    n.trial     = n.sar | (TRIAL_MSB >> (BIT_CNT - n.left)); // RULE_17
  end

  // reset clears all sequencer state and abandons any conversion; power still follows the on input
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0; // RULE_10
    end else begin
      q <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign go_busy              = q.go;
  assign conversion_done_flag = q.flag;
  assign converter_irq        = q.flag & conversion_irq_enable; // RULE_04
  assign wake_request         = device_sleep & converter_irq; // RULE_05
  assign result_high_byte     = q.hi;
  assign result_low_byte      = q.lo;
  assign sar_trial_code       = q.trial;
  assign hold_connected       = ~q.hold_open;
  assign mux_channel          = q.chan;
  // power gate keeps the on bit untouched, as software still sees it set
  assign converter_powered    = converter_on & ~q.pd; // RULE_12 RULE_13
  assign mux_connected        = converter_powered; // RULE_19
  assign timer_one_clear      = q.t1clr;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  sequence last_half_s;
    q.st == ST_CONV && tad_if.half_tick && q.ph == 5'h16 && converter_on
    && !go_write_clear && !sleep_kill;
  endsequence

  sequence frc_go_s;
    go_write_set && converter_on && q.st == ST_IDLE && frc_sel
    && !device_sleep;
  endsequence

  sequence abort_s;
    q.st == ST_CONV && go_write_clear && converter_on && !sleep_kill;
  endsequence

  flag_sticky_a: assert property ( // RULE_03
    q.flag && !flag_clear |=> conversion_done_flag)
    else $error("done flag dropped without clear");

  irq_needs_flag_a: assert property ( // RULE_04
    !conversion_done_flag |-> !converter_irq)
    else $error("irq without done flag");

  sleep_wake_a: assert property ( // RULE_05
    device_sleep && conversion_done_flag && conversion_irq_enable
    |-> wake_request)
    else $error("no wake on enabled irq");

  start_go_a: assert property ( // RULE_06
    go_write_set && converter_on && q.st == ST_IDLE && !device_sleep
    |=> go_busy)
    else $error("go did not start conversion");

  off_no_start_a: assert property ( // RULE_20
    go_write_set && !converter_on && !go_busy |=> !go_busy)
    else $error("conversion started while off");

  finish_load_a: assert property ( // RULE_08
    last_half_s |=> !go_busy && conversion_done_flag)
    else $error("finish did not clear go and set flag");

  justify_right_a: assert property ( // RULE_01
    last_half_s and result_justify_select |=> result_high_byte[7:2] == 6'h00)
    else $error("right justified high bits not zero");

  frc_delay_a: assert property ( // RULE_11
    frc_go_s |=> hold_connected [*4] ##1 !hold_connected)
    else $error("rc start delay wrong");

  abort_fill_a: assert property ( // RULE_09
    abort_s and result_justify_select && q.left == 4'h5
    |=> !go_busy && result_low_byte[4:0] == {5{$past(q.sar[5])}})
    else $error("partial result not filled");

  sleep_abort_a: assert property ( // RULE_13
    go_busy && sleep_kill && converter_on |=> !go_busy && !converter_powered)
    else $error("non rc sleep did not abort");

  sleep_pd_a: assert property ( // RULE_12
    last_half_s and device_sleep && !conversion_irq_enable
    |=> !converter_powered && conversion_done_flag)
    else $error("no power down after sleep conversion");

  trigger_a: assert property ( // RULE_14
    special_event_trigger && converter_on && q.st == ST_IDLE && !sleep_kill
    |=> timer_one_clear && go_busy)
    else $error("trigger did not start or clear timer");
endmodule : adcseq_top
`default_nettype wire

// file: verification/adcseq_tb.sv
// Purpose: self-checking bench for the converter sequencer
// Assumes: comparator modelled from a fixed analog code per case
// Notes: inputs change 1 ns after the rising edge of clk_sys
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import adcseq_pkg::*;
  typedef struct packed {
    logic [2:0] sel;
    logic       rj;
    logic       ie;
    logic [9:0] ain;
  } adcseq_row_t;
  localparam int LIMIT = 20000;
  logic       clk_sys = 1'b0;
  logic       arst_n = 1'b0;
  logic       frc_osc = 1'b0;
  logic       converter_on = 1'b0;
  logic       go_write_set = 1'b0;
  logic       go_write_clear = 1'b0;
  logic [2:0] conversion_clock_select = 3'h0;
  logic       result_justify_select = 1'b0;
  logic [4:0] input_channel_select = 5'h00;
  logic       conversion_irq_enable = 1'b0;
  logic       flag_clear = 1'b0;
  logic       device_sleep = 1'b0;
  logic       special_event_trigger = 1'b0;
  logic [9:0] ain = 10'h000;
  logic       comparator_high;
  logic       go_busy, conversion_done_flag, converter_irq, wake_request;
  logic [7:0] result_high_byte, result_low_byte;
  logic [9:0] sar_trial_code;
  logic       hold_connected, mux_connected, converter_powered;
  logic       timer_one_clear;
  logic [4:0] mux_channel;
  int         bad_count = 0;
  int         n_checks = 0;
  int         cycles = 0;
  // ordinary cases: every clock select, both formats, irq on and off
  adcseq_row_t rows [7] = '{
    '{3'h0, 1'b1, 1'b0, 10'h3FF}, '{3'h4, 1'b1, 1'b1, 10'h2A5},
    '{3'h1, 1'b0, 1'b0, 10'h15A}, '{3'h5, 1'b0, 1'b1, 10'h001},
    '{3'h2, 1'b1, 1'b0, 10'h300}, '{3'h6, 1'b0, 1'b0, 10'h0FF},
    '{3'h3, 1'b1, 1'b1, 10'h1C3}};

  ////////////////////////////////////////////////////////////////////
  // clocks; rc oscillator free-runs well below a quarter of clk_sys
  always #4 clk_sys = ~clk_sys;
  always #100 frc_osc = ~frc_osc;
  // ideal comparator against the trial code
  assign comparator_high = (ain >= sar_trial_code);

  adcseq_top DUT (.clk_sys, .arst_n, .frc_osc, .comparator_high,
    .converter_on, .go_write_set, .go_write_clear,
    .conversion_clock_select, .result_justify_select,
    .input_channel_select, .conversion_irq_enable, .flag_clear,
    .device_sleep, .special_event_trigger, .go_busy,
    .conversion_done_flag, .converter_irq, .wake_request,
    .result_high_byte, .result_low_byte, .sar_trial_code,
    .hold_connected, .mux_channel, .mux_connected, .converter_powered,
    .timer_one_clear);

  ////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up

  // a hang is cut short and counted as a mismatch
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      bad_count++;
      wrap_up();
    end
  end

  task automatic chk_bit(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit

  task automatic chk_word(input string nm, input logic [15:0] e,
                          input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word

  task automatic step(input int n = 1);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step

  // result pair as software should see it
  function automatic logic [15:0] pair(input logic rj, input logic [9:0] a);
    return rj ? {6'h00, a} : {a, 6'h00};
  endfunction : pair

  // settle the set-up first so the divider restarts cleanly at go
  task automatic conv(input adcseq_row_t r, output int n);
    conversion_clock_select = r.sel;
    result_justify_select = r.rj;
    conversion_irq_enable = r.ie;
    ain = r.ain;
    step();
    go_write_set = 1'b1;
    step();
    go_write_set = 1'b0;
    chk_bit("busy", 1'b1, go_busy);
    chk_bit("hold", r.sel[1:0] == SEL_FRC, hold_connected);
    chk_word("trial", 16'h0200, {6'h00, sar_trial_code});
    n = 1;
    // poll the busy bit under a bound
    while (go_busy === 1'b1 && n < 3000) begin
      step();
      n++;
    end
  endtask : conv

  task automatic pulse_clear();
    flag_clear = 1'b1;
    step();
    flag_clear = 1'b0;
  endtask : pulse_clear

  ////////////////////////////////////////////////////////////////////
  initial begin
    int n;
    int lo;
    adcseq_row_t r;
    step(6);
    chk_bit("busy_rst", 1'b0, go_busy);
    chk_bit("hold_rst", 1'b1, hold_connected);
    chk_word("res_rst", 16'h0000, {result_high_byte, result_low_byte});
    arst_n = 1'b1;
    // go and trigger while off: no start, timer clear still pulses
    go_write_set = 1'b1;
    step();
    go_write_set = 1'b0;
    special_event_trigger = 1'b1;
    step();
    special_event_trigger = 1'b0;
    chk_bit("tclr_off", 1'b1, timer_one_clear);
    step(2);
    chk_bit("busy_off", 1'b0, go_busy);
    chk_bit("flag_off", 1'b0, conversion_done_flag);
    chk_bit("mux_off", 1'b0, mux_connected);
    // on in its own write, well before any go
    converter_on = 1'b1;
    input_channel_select = 5'h1D;
    step(2);
    chk_bit("mux_on", 1'b1, mux_connected);
    chk_word("chan", 16'h001D, {11'h000, mux_channel});
    foreach (rows[i]) begin
      r = rows[i];
      pulse_clear();
      conv(r, n);
      lo = 23 * (1 << int'({r.sel[1:0], r.sel[2]}));
      chk_bit("done", 1'b0, go_busy);
      chk_bit("flag", 1'b1, conversion_done_flag);
      chk_word("result", pair(r.rj, r.ain), {result_high_byte, result_low_byte});
      chk_bit("irq", r.ie, converter_irq);
      if (r.sel[1:0] != SEL_FRC) begin
        chk_bit("length", 1'b1, n >= lo - 1 && n <= lo + 6);
      end
    end
    step(20);
    chk_bit("sticky", 1'b1, conversion_done_flag);
    pulse_clear();
    step();
    chk_bit("cleared", 1'b0, conversion_done_flag);
    chk_bit("irq_clr", 1'b0, converter_irq);
    // abort mid-way: bit 9 low, later ones high, fill copies a one
    conversion_clock_select = 3'h6;
    result_justify_select = 1'b1;
    ain = 10'h1FF;
    go_write_set = 1'b1;
    step();
    go_write_set = 1'b0;
    step(400);
    go_write_clear = 1'b1;
    step();
    go_write_clear = 1'b0;
    chk_bit("abort_busy", 1'b0, go_busy);
    chk_word("partial", 16'h01FF, {result_high_byte, result_low_byte});
    chk_bit("abort_flag", 1'b0, conversion_done_flag);
    // hardware trigger starts a conversion; user owns the timing
    special_event_trigger = 1'b1;
    step();
    special_event_trigger = 1'b0;
    chk_bit("trig_busy", 1'b1, go_busy);
    chk_bit("tclr", 1'b1, timer_one_clear);
    step(30);
    // sleep without the rc clock aborts and powers down
    device_sleep = 1'b1;
    step();
    chk_bit("slp_busy", 1'b0, go_busy);
    chk_bit("slp_pwr", 1'b0, converter_powered);
    chk_bit("slp_flag", 1'b0, conversion_done_flag);
    chk_word("slp_res", 16'h01FF, {result_high_byte, result_low_byte});
    device_sleep = 1'b0;
    step();
    chk_bit("wake_pwr", 1'b1, converter_powered);
    // rc clock in sleep: delayed start, power down when irq is off
    conversion_clock_select = 3'h3;
    conversion_irq_enable = 1'b0;
    ain = 10'h0A5;
    step();
    go_write_set = 1'b1;
    step();
    go_write_set = 1'b0;
    device_sleep = 1'b1;
    step(3);
    chk_bit("rc_hold4", 1'b1, hold_connected);
    step();
    chk_bit("rc_hold5", 1'b0, hold_connected);
    n = 0;
    while (go_busy === 1'b1 && n < 3000) begin
      step();
      n++;
    end
    chk_bit("rc_flag", 1'b1, conversion_done_flag);
    chk_word("rc_res", 16'h00A5, {result_high_byte, result_low_byte});
    chk_bit("rc_pwr", 1'b0, converter_powered);
    chk_bit("no_wake", 1'b0, wake_request);
    conversion_irq_enable = 1'b1;
    step();
    chk_bit("wake", 1'b1, wake_request);
    device_sleep = 1'b0;
    // converter switched off mid-way: go drops, nothing is loaded
    conversion_clock_select = 3'h6;
    go_write_set = 1'b1;
    step();
    go_write_set = 1'b0;
    step(30);
    converter_on = 1'b0;
    step();
    chk_bit("off_busy", 1'b0, go_busy);
    chk_bit("off_flag", 1'b1, conversion_done_flag);
    chk_word("off_res", 16'h00A5, {result_high_byte, result_low_byte});
    chk_bit("off_mux", 1'b0, mux_connected);
    converter_on = 1'b1;
    step();
    // reset in mid-conversion
    go_write_set = 1'b1;
    step();
    go_write_set = 1'b0;
    step(30);
    arst_n = 1'b0;
    step();
    chk_bit("rst_busy", 1'b0, go_busy);
    chk_bit("rst_flag", 1'b0, conversion_done_flag);
    chk_word("rst_res", 16'h0000, {result_high_byte, result_low_byte});
    arst_n = 1'b1;
    step(2);
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
